// ==== src/periph_irq_consts.svh ====
// constants for the peripheral interrupt sources block
`ifndef PERIPH_IRQ_CONSTS_SVH
`define PERIPH_IRQ_CONSTS_SVH
`define RESET_VECTOR 32'h0000_0000
`define EXC_VECTOR 32'h0000_0020
`define IRQ_TIMER0 5'h00
`define IRQ_KEYS 5'h01
`define IRQ_TIMER1 5'h02
`define IRQ_AUDIO 5'h06
`define IRQ_PS2 5'h07
`define IRQ_DEBUG 5'h08
`define IRQ_UART 5'h0A
`define IRQ_EXP1 5'h0B
`define IRQ_EXP2 5'h0C
`define OFS_PORT_DATA 5'h00
`define OFS_PORT_MASK 5'h08
`define OFS_PORT_EDGE 5'h0C
`define OFS_TMR_STATUS 5'h00
`define OFS_TMR_CTRL 5'h04
`define OFS_TMR_PERL 5'h08
`define OFS_TMR_PERH 5'h0C
`define OFS_TMR_SNAPL 5'h10
`define OFS_TMR_SNAPH 5'h14
`define OFS_DBG_DATA 5'h00
`define OFS_DBG_CTRL 5'h04
`define BIT_TIMEOUT 0
`define BIT_RUNNING 1
`define BIT_TO_IRQ_EN 0
`define BIT_CONTINUOUS_MODE 1
`define BIT_START 2
`define BIT_STOP 3
`define BIT_RX_EN 0
`define BIT_TX_EN 1
`define BIT_RX_PEND 8
`define BIT_TX_PEND 9
`define BIT_RX_VALID 15
`define FIFO_IRQ_THRESH 16'h0007
`define TMR_DEFAULT_PERIOD 32'h00BE_BC20
`define CLK_HZ 200000000
`define TIMER_HZ 100000000
`endif

// ==== src/periph_irq_pkg.sv ====
// types shared by the peripheral interrupt sources block
package periph_irq_pkg;
  typedef enum logic [2:0] {
    PER_TIMER0 = 3'h0,
    PER_TIMER1 = 3'h1,
    PER_KEYS = 3'h2,
    PER_DEBUG = 3'h3,
    PER_EXP1 = 3'h4,
    PER_EXP2 = 3'h5
  } periph_e;
  typedef struct packed {
    logic rd;
    logic wr;
    periph_e sel;
    logic [4:0] offset;
    logic [31:0] wdata;
  } bus_req_s;
  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } bus_rsp_s;
endpackage

// ==== src/periph_irq_sources.sv ====
// interrupt sources of the peripherals: ports, timers, debug serial port
//
// Contract
// - reset vector is byte address zero
// - exceptions and interrupts share handler 0x20
// - timer0 line 0, keys 1, timer1 2
// - audio line 6, ps2 7, debug 8
// - uart line 10, expansion ports 11, 12
// - parallel port mask register at offset 8
// - mask one enables, zero suppresses bit
// - edge capture at 0xC latches rising inputs
// - any edge capture write clears all bits but those rising in that cycle
// - enabled key press raises interrupt request
// - key press sets its edge capture bit
// - fill count in data, space in control
// - two bits enable receive and transmit interrupts
// - interrupt while count or space exceeds seven
// - pending flags shown; data access clears condition
// - timeout flag set when counter hits zero
// - timeout enable makes timeout request interrupt
// - any status write clears timeout; a zero hit in the same cycle keeps it set
// - reload at zero; continue or stop
// - start and stop bits; running status
// - snapshot low write copies counter to snapshot
`timescale 1ns/1ps
`default_nettype none
`include "periph_irq_consts.svh"
module periph_irq_sources #(
  parameter int KEY_WIDTH = 4,
  parameter int EXP_WIDTH = 32,
  parameter logic [31:0] TMR_PERIOD = `TMR_DEFAULT_PERIOD
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // processor register access
  input wire periph_irq_pkg::bus_req_s busReq,
  output periph_irq_pkg::bus_rsp_s busRsp,
  // parallel port inputs, keys active high when pressed
  input wire logic [KEY_WIDTH-1:0] keysPressed,
  input wire logic [EXP_WIDTH-1:0] exp1In,
  input wire logic [EXP_WIDTH-1:0] exp2In,
  // debug serial port fifo side
  input wire logic [15:0] rxFillCount,
  input wire logic [7:0] rxChar,
  input wire logic [15:0] txFreeSpace,
  output logic rxPop,
  output logic txPush,
  output logic [7:0] txChar,
  // requests from peripherals outside this block
  input wire logic audioIrq,
  input wire logic ps2Irq,
  input wire logic uartIrq,
  // to the processor core
  output logic [31:0] resetVector,
  output logic [31:0] exceptionVector,
  output logic [31:0] irqLines
);
  localparam int DIV = `CLK_HZ / `TIMER_HZ;
  localparam int NP = 3;
  localparam int NT = 2;

  // refuse widths the 32-bit ports cannot hold, dividers above 16
  if (KEY_WIDTH < 1 || KEY_WIDTH > 32 || EXP_WIDTH < 1 ||
      EXP_WIDTH > 32 || DIV < 1 || DIV > 16) begin : g_badParams
    $error("unsupported parameter values");
  end

  // write strobe for one register of one peripheral
  function automatic logic hitW(input periph_irq_pkg::bus_req_s r,
                                input periph_irq_pkg::periph_e s,
                                input logic [4:0] o);
    hitW = r.wr && r.sel == s && r.offset == o;
  endfunction

  // which peripheral a parallel port index answers as
  function automatic periph_irq_pkg::periph_e portSel(input int i);
    case (i)
      0: portSel = periph_irq_pkg::PER_KEYS;
      1: portSel = periph_irq_pkg::PER_EXP1;
      default: portSel = periph_irq_pkg::PER_EXP2;
    endcase
  endfunction

  function automatic periph_irq_pkg::periph_e tmrSel(input int i);
    tmrSel = (i == 0) ? periph_irq_pkg::PER_TIMER0
                      : periph_irq_pkg::PER_TIMER1;
  endfunction

  // ---------------- parallel ports ----------------
  logic [31:0] portIn [NP];
  logic [31:0] portPrev [NP];
  logic [31:0] mask [NP];
  logic [31:0] edgeCap [NP];
  logic [31:0] rise [NP];
  logic clrEdge [NP];

  assign portIn[0] = 32'(keysPressed);
  assign portIn[1] = 32'(exp1In);
  assign portIn[2] = 32'(exp2In);

  always_comb begin
    for (int i = 0; i < NP; i++) begin
      rise[i] = portIn[i] & ~portPrev[i];
      clrEdge[i] = hitW(busReq, portSel(i), `OFS_PORT_EDGE);
    end
  end

  // mask registers, one per port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NP; i++) mask[i] <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (hitW(busReq, portSel(i), `OFS_PORT_MASK)) begin
          mask[i] <= busReq.wdata;
        end
      end
    end
  end

  // edge capture: a rise in the clearing cycle survives the clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NP; i++) begin
        portPrev[i] <= 32'h0000_0000;
        edgeCap[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < NP; i++) begin
        portPrev[i] <= portIn[i];
        if (clrEdge[i]) edgeCap[i] <= rise[i];
        else edgeCap[i] <= edgeCap[i] | rise[i];
      end
    end
  end

  // ---------------- interval timers ----------------
  logic [3:0] divCnt;
  logic tick;
  logic [31:0] count [NT];
  logic [31:0] period [NT];
  logic [31:0] snap [NT];
  logic timeout [NT];
  logic running [NT];
  logic toIrqEn [NT];
  logic contMode [NT];

  // counters step at the timer rate, a fraction of clk
  assign tick = divCnt == 4'(DIV - 1);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) divCnt <= 4'h0;
    else if (tick) divCnt <= 4'h0;
    else divCnt <= divCnt + 4'h1;
  end

  // control bits; start or stop act only as writes of one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int t = 0; t < NT; t++) begin
        toIrqEn[t] <= 1'b0;
        contMode[t] <= 1'b0;
      end
    end else begin
      for (int t = 0; t < NT; t++) begin
        if (hitW(busReq, tmrSel(t), `OFS_TMR_CTRL)) begin
          toIrqEn[t] <= busReq.wdata[`BIT_TO_IRQ_EN];
          contMode[t] <= busReq.wdata[`BIT_CONTINUOUS_MODE];
        end
      end
    end
  end

  // period halves, counter, run state and snapshot
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int t = 0; t < NT; t++) begin
        period[t] <= TMR_PERIOD;
        count[t] <= TMR_PERIOD;
        snap[t] <= 32'h0000_0000;
        running[t] <= 1'b0;
      end
    end else begin
      for (int t = 0; t < NT; t++) begin
        if (hitW(busReq, tmrSel(t), `OFS_TMR_PERL)) begin
          period[t][15:0] <= busReq.wdata[15:0];
          count[t] <= {period[t][31:16], busReq.wdata[15:0]};
        end else if (hitW(busReq, tmrSel(t), `OFS_TMR_PERH)) begin
          period[t][31:16] <= busReq.wdata[15:0];
          count[t] <= {busReq.wdata[15:0], period[t][15:0]};
        end else if (running[t] && tick) begin
          if (count[t] == 32'h0000_0000) begin
            count[t] <= period[t];
            running[t] <= contMode[t];
          end else begin
            count[t] <= count[t] - 32'h0000_0001;
          end
        end
        if (hitW(busReq, tmrSel(t), `OFS_TMR_CTRL)) begin
          if (busReq.wdata[`BIT_STOP]) running[t] <= 1'b0;
          else if (busReq.wdata[`BIT_START]) running[t] <= 1'b1;
        end
        if (hitW(busReq, tmrSel(t), `OFS_TMR_SNAPL)) begin
          snap[t] <= count[t];
        end
      end
    end
  end

  // timeout flag: hitting zero wins over a clearing status write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int t = 0; t < NT; t++) timeout[t] <= 1'b0;
    end else begin
      for (int t = 0; t < NT; t++) begin
        if (running[t] && tick && count[t] == 32'h0000_0000) begin
          timeout[t] <= 1'b1;
        end else if (hitW(busReq, tmrSel(t), `OFS_TMR_STATUS)) begin
          timeout[t] <= 1'b0;
        end
      end
    end
  end

  // ---------------- debug serial port ----------------
  logic rxIrqEn;
  logic txIrqEn;
  logic rxPend;
  logic txPend;
  logic dataRd;
  logic dataWr;

  assign dataRd = busReq.rd && busReq.sel == periph_irq_pkg::PER_DEBUG &&
                  busReq.offset == `OFS_DBG_DATA;
  assign dataWr = hitW(busReq, periph_irq_pkg::PER_DEBUG, `OFS_DBG_DATA);

  // enables, and fifo strobes; popping lowers the fill count outside
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxIrqEn <= 1'b0;
      txIrqEn <= 1'b0;
      rxPop <= 1'b0;
      txPush <= 1'b0;
      txChar <= 8'h00;
    end else begin
      if (hitW(busReq, periph_irq_pkg::PER_DEBUG, `OFS_DBG_CTRL)) begin
        rxIrqEn <= busReq.wdata[`BIT_RX_EN];
        txIrqEn <= busReq.wdata[`BIT_TX_EN];
      end
      rxPop <= dataRd && rxFillCount != 16'h0000;
      txPush <= dataWr && txFreeSpace != 16'h0000;
      if (dataWr) txChar <= busReq.wdata[7:0];
    end
  end

  // pending follows the fifo levels, so a receive pop or transmit push that leaves the level at seven or below clears it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxPend <= 1'b0;
      txPend <= 1'b0;
    end else begin
      rxPend <= rxIrqEn && rxFillCount > `FIFO_IRQ_THRESH;
      txPend <= txIrqEn && txFreeSpace > `FIFO_IRQ_THRESH;
    end
  end

  // ---------------- irq lines and vectors ----------------
  logic [31:0] next_irqLines;
  always_comb begin
    next_irqLines = 32'h0000_0000;
    next_irqLines[`IRQ_TIMER0] = timeout[0] && toIrqEn[0];
    next_irqLines[`IRQ_KEYS] = |(edgeCap[0] & mask[0]);
    next_irqLines[`IRQ_TIMER1] = timeout[1] && toIrqEn[1];
    next_irqLines[`IRQ_AUDIO] = audioIrq;
    next_irqLines[`IRQ_PS2] = ps2Irq;
    next_irqLines[`IRQ_DEBUG] = rxPend || txPend;
    next_irqLines[`IRQ_UART] = uartIrq;
    next_irqLines[`IRQ_EXP1] = |(edgeCap[1] & mask[1]);
    next_irqLines[`IRQ_EXP2] = |(edgeCap[2] & mask[2]);
  end

  // held levels; the core reads these as its pending set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqLines <= 32'h0000_0000;
      resetVector <= `RESET_VECTOR;
      exceptionVector <= `EXC_VECTOR;
    end else begin
      irqLines <= next_irqLines;
      resetVector <= `RESET_VECTOR;
      exceptionVector <= `EXC_VECTOR;
    end
  end

  // ---------------- register read ----------------
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    for (int i = 0; i < NP; i++) begin
      if (busReq.sel == portSel(i)) begin
        case (busReq.offset)
          `OFS_PORT_DATA: next_rdata = portIn[i];
          `OFS_PORT_MASK: next_rdata = mask[i];
          `OFS_PORT_EDGE: next_rdata = edgeCap[i];
          default: next_rdata = 32'h0000_0000;
        endcase
      end
    end
    for (int t = 0; t < NT; t++) begin
      if (busReq.sel == tmrSel(t)) begin
        case (busReq.offset)
          `OFS_TMR_STATUS: next_rdata = {30'h0, running[t], timeout[t]};
          `OFS_TMR_CTRL: next_rdata = {30'h0, contMode[t], toIrqEn[t]};
          `OFS_TMR_PERL: next_rdata = {16'h0000, period[t][15:0]};
          `OFS_TMR_PERH: next_rdata = {16'h0000, period[t][31:16]};
          `OFS_TMR_SNAPL: next_rdata = {16'h0000, snap[t][15:0]};
          `OFS_TMR_SNAPH: next_rdata = {16'h0000, snap[t][31:16]};
          default: next_rdata = 32'h0000_0000;
        endcase
      end
    end
    if (busReq.sel == periph_irq_pkg::PER_DEBUG) begin
      case (busReq.offset)
        `OFS_DBG_DATA: next_rdata = {rxFillCount,
          (rxFillCount != 16'h0000), 7'h00, rxChar};
        `OFS_DBG_CTRL: next_rdata = {txFreeSpace, 6'h00,
          txPend, rxPend, 6'h00, txIrqEn, rxIrqEn};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busRsp <= '0;
    end else begin
      busRsp.valid <= busReq.rd;
      busRsp.rdata <= busReq.rd ? next_rdata : 32'h0000_0000;
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_t0_wrap;
    running[0] && tick && count[0] == 32'h0000_0000;
  endsequence
  sequence s_t0_stop;
    !contMode[0] && !hitW(busReq, periph_irq_pkg::PER_TIMER0, `OFS_TMR_CTRL);
  endsequence

  a_timeout_set: assert property (s_t0_wrap |=> timeout[0])
    else $error("timeout not set at zero");
  a_oneshot_stop: assert property ((s_t0_wrap and s_t0_stop) |=>
    !running[0] && count[0] == period[0])
    else $error("one-shot timer kept running");
  a_timer_irq: assert property (timeout[0] && toIrqEn[0] |=>
    irqLines[0])
    else $error("timer irq missing");
  a_status_clear: assert property (
    hitW(busReq, periph_irq_pkg::PER_TIMER0, `OFS_TMR_STATUS) &&
    !(running[0] && tick && count[0] == 32'h0000_0000)
    |=> !timeout[0] ##1 !irqLines[0])
    else $error("status write did not clear timeout");
  a_edge_latch: assert property (rise[0] != 32'h0000_0000 |=>
    (edgeCap[0] & $past(rise[0])) == $past(rise[0]))
    else $error("key press not captured");
  a_edge_clear: assert property (clrEdge[0] && rise[0] == 32'h0000_0000
    |=> edgeCap[0] == 32'h0000_0000)
    else $error("edge capture not cleared");
  a_key_irq: assert property ((edgeCap[0] & mask[0]) != 32'h0000_0000
    |=> irqLines[1])
    else $error("key irq missing");
  a_mask_block: assert property (mask[0] == 32'h0000_0000 |=>
    !irqLines[1])
    else $error("masked key raised irq");
  a_rx_irq: assert property (rxIrqEn && rxFillCount > `FIFO_IRQ_THRESH
    |=> rxPend ##1 irqLines[8])
    else $error("receive irq missing");
  a_snap_copy: assert property (
    hitW(busReq, periph_irq_pkg::PER_TIMER0, `OFS_TMR_SNAPL)
    |=> snap[0] == $past(count[0]))
    else $error("snapshot mismatch");
endmodule
`default_nettype wire

// ==== sim/debug_fifo_model.sv ====
// far-side model of the debug serial port fifos
`timescale 1ns/1ps
`default_nettype none
module debug_fifo_model #(
  parameter logic [15:0] RX_INIT = 16'h0008,
  parameter logic [15:0] TX_INIT = 16'h0008
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // block side
  input wire logic rxPop,
  input wire logic txPush,
  input wire logic [7:0] txChar,
  output logic [15:0] rxFillCount,
  output logic [7:0] rxChar,
  output logic [15:0] txFreeSpace,
  // last character taken
  output logic [7:0] lastTx
);
  // levels move only on pops and pushes, as the real fifos do
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxFillCount <= RX_INIT;
      txFreeSpace <= TX_INIT;
      lastTx <= 8'h00;
    end else begin
      if (rxPop && rxFillCount != 16'h0000) begin
        rxFillCount <= rxFillCount - 16'h0001;
      end
      if (txPush && txFreeSpace != 16'h0000) begin
        txFreeSpace <= txFreeSpace - 16'h0001;
        lastTx <= txChar;
      end
    end
  end
  // char follows the level so a stale read is visible
  assign rxChar = 8'h50 + rxFillCount[7:0];
endmodule
`default_nettype wire

// ==== sim/peripheral_interrupt_sources_bench.sv ====
// self-checking bench for the peripheral interrupt sources
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_sources_bench;
  typedef struct packed {
    periph_irq_pkg::periph_e sel;
    logic [4:0] ofs;
    logic [31:0] wd;
    logic [31:0] rd;
  } row_s;
  logic clk;
  logic arst_n;
  periph_irq_pkg::bus_req_s req;
  periph_irq_pkg::bus_rsp_s rsp;
  logic [3:0] keys;
  logic [31:0] exp1;
  logic [31:0] exp2;
  logic [2:0] ext;
  logic rxPop;
  logic txPush;
  logic [7:0] txChar;
  logic [15:0] rxFill;
  logic [7:0] rxChar;
  logic [15:0] txFree;
  logic [7:0] lastTx;
  logic [31:0] resetVector;
  logic [31:0] exceptionVector;
  logic [31:0] irqLines;
  int failCount = 0;
  int checkCount = 0;
  int cycles = 0;
  row_s rows [6];
  int extLine [3] = '{6, 7, 10};

  periph_irq_sources #(.TMR_PERIOD(32'h0000_0014)) u_periph_irq_sources (
    .clk(clk), .arst_n(arst_n), .busReq(req), .busRsp(rsp),
    .keysPressed(keys), .exp1In(exp1), .exp2In(exp2),
    .rxFillCount(rxFill), .rxChar(rxChar), .txFreeSpace(txFree),
    .rxPop(rxPop), .txPush(txPush), .txChar(txChar),
    .audioIrq(ext[0]), .ps2Irq(ext[1]), .uartIrq(ext[2]),
    .resetVector(resetVector), .exceptionVector(exceptionVector),
    .irqLines(irqLines));

  debug_fifo_model u_debug_fifo_model (
    .clk(clk), .arst_n(arst_n), .rxPop(rxPop), .txPush(txPush),
    .txChar(txChar), .rxFillCount(rxFill), .rxChar(rxChar),
    .txFreeSpace(txFree), .lastTx(lastTx));

  task automatic summarize();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want,
                       input string what);
    checkCount++;
    if (seen !== want) begin
      failCount++;
      $display("wrong value at %0t: %s seen %h want %h", $time, what,
               seen, want);
    end
  endtask

  // writes take effect at the edge; a spare edge keeps strobes apart
  task automatic busWr(input periph_irq_pkg::periph_e s,
                       input logic [4:0] o, input logic [31:0] d);
    req.wr = 1'b1;
    req.sel = s;
    req.offset = o;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
    @(negedge clk);
  endtask

  // read, wait for the one-cycle answer, compare its data
  task automatic rdChk(input periph_irq_pkg::periph_e s,
                       input logic [4:0] o, input logic [31:0] want);
    int n;
    n = 0;
    req.rd = 1'b1;
    req.sel = s;
    req.offset = o;
    @(negedge clk);
    req.rd = 1'b0;
    while (rsp.valid !== 1'b1 && n < 3) begin
      @(negedge clk);
      n++;
    end
    check({31'h0000_0000, rsp.valid}, 32'h0000_0001, "answer");
    check(rsp.rdata, want, "read data");
    @(negedge clk);
  endtask

  // bounded wait for an irq line to reach a level
  task automatic waitIrq(input int b, input logic val, input int lim);
    int n;
    n = 0;
    while (irqLines[b] !== val && n < lim) begin
      @(negedge clk);
      n++;
    end
    check({31'h0000_0000, irqLines[b]}, {31'h0000_0000, val}, "irq line");
  endtask

  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // hang guard: the tests need well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      summarize();
    end
  end

  initial begin
    arst_n = 1'b0;
    req = '0;
    keys = 4'h0;
    exp1 = 32'h0000_0000;
    exp2 = 32'h0000_0000;
    ext = 3'h0;
    rows = '{
      '{periph_irq_pkg::PER_KEYS, 5'h08, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
      '{periph_irq_pkg::PER_EXP1, 5'h08, 32'hA5A5_A5A5, 32'hA5A5_A5A5},
      '{periph_irq_pkg::PER_EXP2, 5'h08, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
      '{periph_irq_pkg::PER_TIMER1, 5'h0C, 32'h0000_0000, 32'h0000_0000},
      '{periph_irq_pkg::PER_TIMER1, 5'h08, 32'hABCD_0010, 32'h0000_0010},
      '{periph_irq_pkg::PER_KEYS, 5'h04, 32'hFFFF_FFFF, 32'h0000_0000}};
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    check(resetVector, 32'h0000_0000, "reset vector");
    check(exceptionVector, 32'h0000_0020, "handler");
    check(irqLines, 32'h0000_0000, "lines idle");
    $display("done: reset");
    // ordinary register rows: write then read back
    foreach (rows[i]) begin
      busWr(rows[i].sel, rows[i].ofs, rows[i].wd);
      rdChk(rows[i].sel, rows[i].ofs, rows[i].rd);
    end
    $display("done: table");
    // outside requests pass to their fixed lines
    for (int i = 0; i < 3; i++) begin
      ext = 3'h1 << i;
      waitIrq(extLine[i], 1'b1, 4);
      ext = 3'h0;
      waitIrq(extLine[i], 1'b0, 4);
    end
    $display("done: outside lines");
    // key presses, mask and clear by any write
    busWr(periph_irq_pkg::PER_KEYS, 5'h08, 32'h0000_0001);
    keys = 4'h1;
    waitIrq(1, 1'b1, 5);
    keys = 4'h3;
    repeat (3) @(negedge clk);
    rdChk(periph_irq_pkg::PER_KEYS, 5'h0C, 32'h0000_0003);
    busWr(periph_irq_pkg::PER_KEYS, 5'h0C, 32'h0000_0000);
    waitIrq(1, 1'b0, 5);
    rdChk(periph_irq_pkg::PER_KEYS, 5'h0C, 32'h0000_0000);
    keys = 4'h0;
    @(negedge clk);
    keys = 4'h2;
    repeat (4) @(negedge clk);
    check({31'h0000_0000, irqLines[1]}, 32'h0000_0000, "masked");
    exp1 = 32'h0000_0020;
    waitIrq(11, 1'b1, 5);
    exp2 = 32'h8000_0000;
    waitIrq(12, 1'b1, 5);
    $display("done: parallel ports");
    // one-shot timer, then snapshot of the reloaded count
    busWr(periph_irq_pkg::PER_TIMER0, 5'h08, 32'h0000_000A);
    busWr(periph_irq_pkg::PER_TIMER0, 5'h0C, 32'h0000_0000);
    busWr(periph_irq_pkg::PER_TIMER0, 5'h04, 32'h0000_0005);
    waitIrq(0, 1'b1, 60);
    rdChk(periph_irq_pkg::PER_TIMER0, 5'h00, 32'h0000_0001);
    busWr(periph_irq_pkg::PER_TIMER0, 5'h10, 32'h0000_0000);
    rdChk(periph_irq_pkg::PER_TIMER0, 5'h10, 32'h0000_000A);
    busWr(periph_irq_pkg::PER_TIMER0, 5'h00, 32'h0000_FFFF);
    waitIrq(0, 1'b0, 4);
    // continuous second timer keeps running until stopped
    busWr(periph_irq_pkg::PER_TIMER1, 5'h04, 32'h0000_0007);
    waitIrq(2, 1'b1, 80);
    rdChk(periph_irq_pkg::PER_TIMER1, 5'h00, 32'h0000_0003);
    busWr(periph_irq_pkg::PER_TIMER1, 5'h00, 32'h0000_0000);
    waitIrq(2, 1'b0, 4);
    waitIrq(2, 1'b1, 80);
    busWr(periph_irq_pkg::PER_TIMER1, 5'h04, 32'h0000_0008);
    rdChk(periph_irq_pkg::PER_TIMER1, 5'h00, 32'h0000_0001);
    $display("done: timers");
    // debug port: threshold at eight, a receive pop or a transmit push clears it
    busWr(periph_irq_pkg::PER_DEBUG, 5'h04, 32'h0000_0001);
    waitIrq(8, 1'b1, 5);
    rdChk(periph_irq_pkg::PER_DEBUG, 5'h04, 32'h0008_0101);
    rdChk(periph_irq_pkg::PER_DEBUG, 5'h00, 32'h0008_8058);
    waitIrq(8, 1'b0, 5);
    busWr(periph_irq_pkg::PER_DEBUG, 5'h04, 32'h0000_0002);
    waitIrq(8, 1'b1, 5);
    busWr(periph_irq_pkg::PER_DEBUG, 5'h00, 32'h0000_0033);
    waitIrq(8, 1'b0, 5);
    check({24'h00_0000, lastTx}, 32'h0000_0033, "sent char");
    rdChk(periph_irq_pkg::PER_DEBUG, 5'h04, 32'h0007_0002);
    $display("done: debug port");
    // reset in mid-run: lines drop at once, registers return to reset
    @(negedge clk);
    arst_n = 1'b0;
    @(negedge clk);
    check(irqLines, 32'h0000_0000, "lines in reset");
    check(resetVector, 32'h0000_0000, "vector in reset");
    arst_n = 1'b1;
    @(negedge clk);
    rdChk(periph_irq_pkg::PER_EXP2, 5'h08, 32'h0000_0000);
    rdChk(periph_irq_pkg::PER_TIMER1, 5'h00, 32'h0000_0000);
    // the held-high input shows as a rise, but its mask is now zero
    rdChk(periph_irq_pkg::PER_EXP2, 5'h0C, 32'h8000_0000);
    waitIrq(12, 1'b0, 4);
    $display("done: mid-run reset");
    summarize();
  end
endmodule
`default_nettype wire
